// ### design/ieu_pkg.sv
/*
  Shared constants and types of the instruction execute unit: operation
  codes, flag layout, register offsets, reset values and port carriers.
  Assumes a single 100 MHz system clock and an AXI4-Lite register bus.
*/
package ieu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and timing
  localparam int unsigned DATA_W = 8;
  localparam int unsigned MADDR_W = 8;
  localparam int unsigned PC_W = 9;
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // extra instruction cycle after a pc low byte write, in system clocks
  localparam logic [2:0] PCL_EXTRA_CLKS = 3'h4;
  localparam logic [MADDR_W-1:0] PCL_ADDR = 8'h02;

  ////////////////////////////////////////////////////////////////////////////
  // decimal adjust constants
  localparam logic [4:0] BCD_ADJ = 5'h06;
  localparam logic [4:0] BCD_MAX = 5'h09;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam logic [AXI_AW-1:0] REG_WORK = 8'h00;
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [AXI_AW-1:0] REG_WDOG = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // status flags, bit 0 is carry
  typedef struct packed {
    logic to;
    logic pd;
    logic ov;
    logic z;
    logic ac;
    logic c;
  } ieu_flags_t;
  localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
  localparam ieu_flags_t FLAGS_RST = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // operations
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADC_W = 5'h01, OP_ADC_M = 5'h02, OP_ADD_W = 5'h03,
    OP_ADD_M = 5'h04, OP_ADD_I = 5'h05, OP_AND_W = 5'h06, OP_AND_I = 5'h07,
    OP_AND_M = 5'h08, OP_CALL = 5'h09, OP_CLR_M = 5'h0a, OP_CLR_BIT = 5'h0b,
    OP_WD_KICK = 5'h0c, OP_WD_PRE1 = 5'h0d, OP_WD_PRE2 = 5'h0e,
    OP_INV_M = 5'h0f, OP_INV_W = 5'h10, OP_BCD = 5'h11, OP_DEC_M = 5'h12,
    OP_DEC_W = 5'h13, OP_HALT = 5'h14
  } ieu_op_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_STALL = 3'h2,
    ST_SLEEP = 3'h4
  } ieu_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // port carriers
  typedef struct packed {
    ieu_op_t op;
    logic [MADDR_W-1:0] addr;
    logic [DATA_W-1:0] imm;
    logic [2:0] bit_sel;
    logic [PC_W-1:0] target;
    logic [PC_W-1:0] pc;
  } ieu_issue_t;

  typedef struct packed {
    logic we;
    logic [MADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ieu_mem_wr_t;

  typedef struct packed {
    logic we;
    logic [PC_W-1:0] data;
  } ieu_pc_t;

endpackage : ieu_pkg

// ### design/ieu_exec.sv
/*
  Execute datapath of an 8-bit controller core: arithmetic, logic, clear,
  call and watchdog clear operations, with an AXI4-Lite register window.
  Assumes the operand byte of data memory is presented with the issue and
  that memory, stack and watchdog counter live outside this block.
*/
`timescale 1ns/100ps
module ieu_exec
  import ieu_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // instruction issue
  input wire logic issue_valid,
  output logic issue_ready,
  input ieu_pkg::ieu_issue_t issue,
  input wire logic [ieu_pkg::DATA_W-1:0] mem_rdata,
  // data memory write
  output ieu_pkg::ieu_mem_wr_t mem_wr,
  // return stack push and program counter load
  output ieu_pkg::ieu_pc_t stack_push,
  output ieu_pkg::ieu_pc_t pc_load,
  // watchdog and power down
  output logic wdt_clear,
  input wire logic wdt_expired,
  input wire logic wake,
  output logic clk_stop,
  // axi4-lite slave
  input wire logic [ieu_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ieu_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import ieu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // all state of the block
  typedef struct packed {
    ieu_state_t st;
    logic [2:0] cnt;
    logic [DATA_W-1:0] work;
    ieu_flags_t fl;
    logic mark1;
    logic mark2;
    ieu_mem_wr_t mem;
    ieu_pc_t push;
    ieu_pc_t pcld;
    logic wdt_clr;
    logic aw_held;
    logic [AXI_AW-1:0] aw_addr;
    logic w_held;
    logic [DATA_W-1:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ieu_core_t;

  localparam ieu_core_t CORE_RST = '{
    st: ST_RUN, work: WORK_RST, fl: FLAGS_RST, default: '0
  };

  ieu_core_t s;
  ieu_core_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // 8-bit add returning {ov, ac, c, sum}
  function automatic logic [10:0] ieu_add8(
    input logic [7:0] a,
    input logic [7:0] b,
    input logic cin
  );
    logic [4:0] lo;
    logic [8:0] full;
    logic ov;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    ov = (a[7] == b[7]) && (full[7] != a[7]);
    return {ov, lo[4], full[8], full[7:0]};
  endfunction : ieu_add8

  ////////////////////////////////////////////////////////////////////////////
  // scratch values of the combinational process
  logic [10:0] add_res;
  logic [7:0] add_b;
  logic add_cin;
  logic [7:0] res;
  logic wr_mem;
  logic wr_work;
  logic set_z;
  logic wd_restart;
  logic [4:0] bcd_lo;
  logic [4:0] bcd_hi;
  logic aw_go;
  logic w_go;
  logic ar_go;

  // handshake outputs
  assign issue_ready = (s.st == ST_RUN);
  assign s_axi_awready = !s.aw_held && !s.bvalid;
  assign s_axi_wready = !s.w_held && !s.bvalid;
  assign s_axi_arready = !s.rvalid;

  // registered outputs
  assign mem_wr = s.mem;
  assign stack_push = s.push;
  assign pc_load = s.pcld;
  assign wdt_clear = s.wdt_clr;
  assign clk_stop = (s.st == ST_SLEEP);
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    next_s = s;
    next_s.mem.we = 1'b0;
    next_s.push.we = 1'b0;
    next_s.pcld.we = 1'b0;
    next_s.wdt_clr = 1'b0;
    res = 8'h00;
    wr_mem = 1'b0;
    wr_work = 1'b0;
    set_z = 1'b0;
    wd_restart = 1'b0;
    bcd_lo = 5'h00;
    bcd_hi = 5'h00;
    aw_go = s_axi_awvalid && s_axi_awready;
    w_go = s_axi_wvalid && s_axi_wready;
    ar_go = s_axi_arvalid && s_axi_arready;
    add_b = (issue.op == OP_ADD_I) ? issue.imm : mem_rdata;
    add_cin = ((issue.op == OP_ADC_W) || (issue.op == OP_ADC_M))
      ? s.fl.c : 1'b0;
    add_res = ieu_add8(s.work, add_b, add_cin);

    // register reads answer in the cycle after the address is taken
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (ar_go)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        REG_WORK: next_s.rdata = 32'(s.work);
        REG_STATUS: next_s.rdata = 32'(s.fl);
        REG_WDOG: next_s.rdata = 32'({s.mark2, s.mark1});
        default:
        begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end

    // write address and data are taken in either order
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
    end
    if (aw_go)
    begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (w_go)
    begin
      next_s.w_held = 1'b1;
      next_s.w_data = s_axi_wdata[DATA_W-1:0];
      next_s.w_lane0 = s_axi_wstrb[0];
    end
    if (s.aw_held && s.w_held)
    begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      unique case (s.aw_addr)
        REG_WORK:
        begin
          if (s.w_lane0)
          begin
            next_s.work = s.w_data;
          end
        end
        REG_STATUS:
        begin
          if (s.w_lane0)
          begin
            next_s.fl = s.w_data[5:0];
          end
        end
        REG_WDOG:
        begin
          next_s.bresp = RESP_OKAY;
        end
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end

    // instruction sequencing
    unique case (s.st)
      ST_RUN:
      begin
        if (issue_valid)
        begin
          unique case (issue.op)
            OP_ADC_W, OP_ADD_W, OP_ADD_I, OP_ADC_M, OP_ADD_M:
            begin
              res = add_res[7:0];
              wr_work = (issue.op == OP_ADC_W)
                || (issue.op == OP_ADD_W)
                || (issue.op == OP_ADD_I);
              wr_mem = !wr_work;
              set_z = 1'b1;
              next_s.fl.ov = add_res[10];
              next_s.fl.ac = add_res[9];
              next_s.fl.c = add_res[8];
            end
            OP_AND_W:
            begin
              res = s.work & mem_rdata;
              wr_work = 1'b1;
              set_z = 1'b1;
            end
            OP_AND_I:
            begin
              res = s.work & issue.imm;
              wr_work = 1'b1;
              set_z = 1'b1;
            end
            OP_AND_M:
            begin
              res = s.work & mem_rdata;
              wr_mem = 1'b1;
              set_z = 1'b1;
            end
            OP_CALL:
            begin
              next_s.push.we = 1'b1;
              next_s.push.data = issue.pc + 1'b1;
              next_s.pcld.we = 1'b1;
              next_s.pcld.data = issue.target;
            end
            OP_CLR_M:
            begin
              res = 8'h00;
              wr_mem = 1'b1;
            end
            OP_CLR_BIT:
            begin
              res = mem_rdata & ~(8'h01 << issue.bit_sel);
              wr_mem = 1'b1;
            end
            OP_WD_KICK:
            begin
              wd_restart = 1'b1;
            end
            OP_WD_PRE1:
            begin
              if (s.mark2)
              begin
                wd_restart = 1'b1;
              end
              else
              begin
                next_s.mark1 = 1'b1;
              end
            end
            OP_WD_PRE2:
            begin
              if (s.mark1)
              begin
                wd_restart = 1'b1;
              end
              else
              begin
                next_s.mark2 = 1'b1;
              end
            end
            OP_INV_M:
            begin
              res = ~mem_rdata;
              wr_mem = 1'b1;
              set_z = 1'b1;
            end
            OP_INV_W:
            begin
              res = ~mem_rdata;
              wr_work = 1'b1;
              set_z = 1'b1;
            end
            OP_BCD:
            begin
              bcd_lo = {1'b0, s.work[3:0]};
              if ((bcd_lo > BCD_MAX) || s.fl.ac)
              begin
                bcd_lo = bcd_lo + BCD_ADJ;
              end
              // carry out of the low nibble feeds the high nibble
              bcd_hi = {1'b0, s.work[7:4]} + {4'h0, bcd_lo[4]};
              if ((bcd_hi > BCD_MAX) || s.fl.c)
              begin
                bcd_hi = bcd_hi + BCD_ADJ;
                next_s.fl.c = 1'b1;
              end
              res = {bcd_hi[3:0], bcd_lo[3:0]};
              wr_mem = 1'b1;
            end
            OP_DEC_M:
            begin
              res = mem_rdata - 8'h01;
              wr_mem = 1'b1;
              set_z = 1'b1;
            end
            OP_DEC_W:
            begin
              res = mem_rdata - 8'h01;
              wr_work = 1'b1;
              set_z = 1'b1;
            end
            OP_HALT:
            begin
              next_s.wdt_clr = 1'b1;
              next_s.fl.pd = 1'b1;
              next_s.fl.to = 1'b0;
              next_s.st = ST_SLEEP;
            end
            OP_NOP:
            begin
              res = 8'h00;
            end
          endcase
          if (set_z)
          begin
            next_s.fl.z = (res == 8'h00);
          end
          if (wr_work)
          begin
            next_s.work = res;
          end
          if (wr_mem)
          begin
            next_s.mem.we = 1'b1;
            next_s.mem.addr = issue.addr;
            next_s.mem.data = res;
            if (issue.addr == PCL_ADDR)
            begin
              next_s.st = ST_STALL;
              next_s.cnt = PCL_EXTRA_CLKS;
            end
          end
          if (wd_restart)
          begin
            next_s.wdt_clr = 1'b1;
            next_s.fl.pd = 1'b0;
            next_s.fl.to = 1'b0;
            next_s.mark1 = 1'b0;
            next_s.mark2 = 1'b0;
          end
        end
      end
      ST_STALL:
      begin
        // hold off the next issue for the extra instruction cycle
        next_s.cnt = s.cnt - 3'h1;
        if (s.cnt == 3'h1)
        begin
          next_s.st = ST_RUN;
        end
      end
      ST_SLEEP:
      begin
        if (wake)
        begin
          next_s.st = ST_RUN;
        end
      end
    endcase

    // an expiry in the same cycle as a clear still sets the flag
    if (wdt_expired)
    begin
      next_s.fl.to = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= CORE_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

endmodule : ieu_exec

// ### sim/ieu_exec_sva.sv
/*
  Checker of the execute unit's issue-side outputs.
  Assumes it is bound to ieu_exec and sees only that module's ports.
*/
`timescale 1ns/100ps
module ieu_exec_chk
  import ieu_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // issue side
  input wire logic issue_valid,
  input wire logic issue_ready,
  input ieu_pkg::ieu_issue_t issue,
  input wire logic [ieu_pkg::DATA_W-1:0] mem_rdata,
  // results
  input ieu_pkg::ieu_mem_wr_t mem_wr,
  input ieu_pkg::ieu_pc_t stack_push,
  input ieu_pkg::ieu_pc_t pc_load,
  input wire logic wdt_clear,
  input wire logic clk_stop
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic take;
  // an instruction is taken at this edge
  assign take = issue_valid && issue_ready;
  ////////////////////////////////////////////////////////////////////////////
  call_push_a: assert property (take && issue.op == OP_CALL |=>
    stack_push.we && stack_push.data == $past(issue.pc) + 9'h001)
    else $error("call pushed a wrong return address");
  call_load_a: assert property (take && issue.op == OP_CALL |=>
    pc_load.we && pc_load.data == $past(issue.target))
    else $error("call loaded a wrong target");
  byte_clear_a: assert property (take && issue.op == OP_CLR_M |=>
    mem_wr.we && mem_wr.data == 8'h00 && mem_wr.addr == $past(issue.addr))
    else $error("byte clear wrote a wrong value");
  bit_clear_a: assert property (take && issue.op == OP_CLR_BIT |=>
    mem_wr.we && mem_wr.data ==
    ($past(mem_rdata) & ~(8'h01 << $past(issue.bit_sel))))
    else $error("bit clear touched other bits");
  invert_mem_a: assert property (take && issue.op == OP_INV_M |=>
    mem_wr.we && mem_wr.data == ~$past(mem_rdata))
    else $error("memory invert wrote a wrong value");
  dec_mem_a: assert property (take && issue.op == OP_DEC_M |=>
    mem_wr.we && mem_wr.data == $past(mem_rdata) - 8'h01)
    else $error("memory decrement wrote a wrong value");
  work_only_a: assert property (take && (issue.op == OP_INV_W ||
    issue.op == OP_DEC_W) |=> !mem_wr.we)
    else $error("work-only operation wrote memory");
  kick_clear_a: assert property (take && issue.op == OP_WD_KICK |=>
    wdt_clear)
    else $error("kick did not restart the watchdog");
  halt_sleep_a: assert property (take && issue.op == OP_HALT |=>
    clk_stop && wdt_clear && !issue_ready)
    else $error("halt did not enter sleep");
  pcl_stall_a: assert property (mem_wr.we && mem_wr.addr == PCL_ADDR |->
    !issue_ready [*4] ##1 issue_ready)
    else $error("pc low byte write stall is not four clocks");
endmodule : ieu_exec_chk

bind ieu_exec ieu_exec_chk chk (.aclk(aclk), .aresetn(aresetn),
  .issue_valid(issue_valid), .issue_ready(issue_ready), .issue(issue),
  .mem_rdata(mem_rdata), .mem_wr(mem_wr), .stack_push(stack_push),
  .pc_load(pc_load), .wdt_clear(wdt_clear), .clk_stop(clk_stop));

// ### sim/ieu_mem_model.sv
/*
  Data memory, return stack top, program counter and watchdog restart
  counter that stand beside the execute unit.
  Assumes write-backs and pushes arrive as one-cycle pulses.
*/
`timescale 1ns/100ps
module ieu_mem_model
  import ieu_pkg::*;
(
  // clock
  input wire logic aclk,
  // operand read and write-back
  input ieu_pkg::ieu_issue_t issue,
  output logic [ieu_pkg::DATA_W-1:0] mem_rdata,
  input ieu_pkg::ieu_mem_wr_t mem_wr,
  // call and watchdog
  input ieu_pkg::ieu_pc_t stack_push,
  input ieu_pkg::ieu_pc_t pc_load,
  input wire logic wdt_clear
);
  logic [7:0] mem [256];
  logic [8:0] stack_top = 9'h000;
  logic [8:0] pc = 9'h000;
  int clr_cnt = 0;
  // memory starts cleared so no unknown operand is ever fed back
  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // operand byte follows the issued address at once
  assign mem_rdata = mem[issue.addr];
  // store write-backs, pushes, loads and watchdog restarts
  always @(posedge aclk)
  begin
    if (mem_wr.we) mem[mem_wr.addr] <= mem_wr.data;
    if (stack_push.we) stack_top <= stack_push.data;
    if (pc_load.we) pc <= pc_load.data;
    if (wdt_clear) clr_cnt <= clr_cnt + 1;
  end
endmodule : ieu_mem_model

// ### sim/test_ieu_exec.sv
/*
  Self-checking bench of the execute unit: operations, watchdog, sleep,
  pc low byte stall and register bus.
  Assumes the memory model beside the unit and the bound checker.
*/
`timescale 1ns/100ps
module test_ieu_exec;
  import ieu_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic issue_valid = 1'b0;
  logic issue_ready;
  ieu_issue_t issue = '0;
  logic [7:0] mem_rdata;
  ieu_mem_wr_t mem_wr;
  ieu_pc_t stack_push;
  ieu_pc_t pc_load;
  logic wdt_clear;
  logic clk_stop;
  logic wdt_expired = 1'b0;
  logic wake = 1'b0;
  logic [7:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  int err_count = 0;
  int cmp_count = 0;
  // 100 MHz system clock
  always #5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  ieu_exec uut (.aclk(aclk), .aresetn(aresetn), .issue_valid(issue_valid),
    .issue_ready(issue_ready), .issue(issue), .mem_rdata(mem_rdata),
    .mem_wr(mem_wr), .stack_push(stack_push), .pc_load(pc_load),
    .wdt_clear(wdt_clear), .wdt_expired(wdt_expired), .wake(wake),
    .clk_stop(clk_stop), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  ieu_mem_model mdl (.aclk(aclk), .issue(issue), .mem_rdata(mem_rdata),
    .mem_wr(mem_wr), .stack_push(stack_push), .pc_load(pc_load),
    .wdt_clear(wdt_clear));
  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic end_sim;
    $display("mismatches %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // one comparison
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // a wait that ran out ends the run
  task automatic tmo(input logic t);
    if (t !== 1'b1)
    begin
      err_count++;
      $display("BAD %0t wait ran out", $time);
      end_sim;
    end
  endtask : tmo
  // bus write, address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    logic ta, tw, t;
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      t = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      n++;
    end
    while (!t && n < 50);
    s_axi_bready <= 1'b0;
    tmo(t);
  endtask : axw
  // bus read
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    logic ta, t;
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      n++;
    end
    while (!t && n < 50);
    s_axi_rready <= 1'b0;
    tmo(t);
  endtask : axr
  // issue one instruction and hold it until taken
  task automatic iss(input ieu_op_t op, input logic [7:0] a,
    input logic [7:0] im);
    logic t;
    int n;
    n = 0;
    @(posedge aclk);
    issue <= '{op: op, addr: a, imm: im, bit_sel: 3'h7, target: 9'h1ab,
      pc: 9'h1ff};
    issue_valid <= 1'b1;
    do
    begin
      @(negedge aclk);
      t = issue_ready;
      @(posedge aclk);
      n++;
    end
    while (!t && n < 50);
    issue_valid <= 1'b0;
    tmo(t);
  endtask : iss
  // read one register and compare it
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d, e);
  endtask : rdc
  // preset work, status and operand, run one op, judge all three
  task automatic alu(input ieu_op_t op, input logic [7:0] w, st, m, ew,
    em, es);
    logic [1:0] r;
    mdl.mem[8'h10] = m;
    axw(REG_WORK, {24'h0, w}, r);
    axw(REG_STATUS, {24'h0, st}, r);
    iss(op, 8'h10, m);
    rdc(REG_WORK, {24'h0, ew});
    rdc(REG_STATUS, {24'h0, es});
    chk({24'h0, mdl.mem[8'h10]}, {24'h0, em});
  endtask : alu
  // arithmetic, logic, clear and adjust table
  task automatic sc_alu;
    alu(OP_ADC_W, 8'h7f, 8'h01, 8'h01, 8'h81, 8'h01, 8'h0a);
    alu(OP_ADC_M, 8'hff, 8'h01, 8'h00, 8'hff, 8'h00, 8'h07);
    alu(OP_ADD_W, 8'h80, 8'h01, 8'h80, 8'h00, 8'h80, 8'h0d);
    alu(OP_ADD_M, 8'h08, 8'h00, 8'h08, 8'h08, 8'h10, 8'h02);
    alu(OP_ADD_I, 8'h01, 8'h3f, 8'h0e, 8'h0f, 8'h0e, 8'h30);
    alu(OP_AND_W, 8'hf0, 8'h2b, 8'h0f, 8'h00, 8'h0f, 8'h2f);
    alu(OP_AND_I, 8'h3c, 8'h04, 8'h0c, 8'h0c, 8'h0c, 8'h00);
    alu(OP_AND_M, 8'hf0, 8'h1b, 8'h30, 8'hf0, 8'h30, 8'h1b);
    alu(OP_CLR_M, 8'h00, 8'h3b, 8'h5a, 8'h00, 8'h00, 8'h3b);
    alu(OP_CLR_BIT, 8'h00, 8'h04, 8'hff, 8'h00, 8'h7f, 8'h04);
    alu(OP_INV_M, 8'h00, 8'h0b, 8'hff, 8'h00, 8'h00, 8'h0f);
    alu(OP_INV_W, 8'h00, 8'h04, 8'ha5, 8'h5a, 8'ha5, 8'h00);
    alu(OP_DEC_M, 8'h00, 8'h0f, 8'h00, 8'h00, 8'hff, 8'h0b);
    alu(OP_DEC_W, 8'h77, 8'h00, 8'h01, 8'h00, 8'h01, 8'h04);
    alu(OP_BCD, 8'h9a, 8'h00, 8'h55, 8'h9a, 8'h00, 8'h01);
    alu(OP_BCD, 8'h15, 8'h02, 8'h55, 8'h15, 8'h1b, 8'h02);
    alu(OP_BCD, 8'h00, 8'h01, 8'h55, 8'h00, 8'h60, 8'h01);
    alu(OP_BCD, 8'h09, 8'h00, 8'h55, 8'h09, 8'h09, 8'h00);
  endtask : sc_alu
  // call at the top of program space, flags kept
  task automatic sc_call;
    logic [1:0] r;
    axw(REG_STATUS, 32'h0f, r);
    iss(OP_CALL, 8'h10, 8'h00);
    rdc(REG_STATUS, 32'h0f);
    chk({23'h0, mdl.stack_top}, 32'h000);
    chk({23'h0, mdl.pc}, 32'h1ab);
  endtask : sc_call
  // kick, lone prekicks and completed pairs
  task automatic sc_wdog;
    logic [1:0] r;
    int c;
    c = mdl.clr_cnt;
    axw(REG_STATUS, 32'h30, r);
    iss(OP_WD_KICK, 8'h10, 8'h00);
    rdc(REG_STATUS, 32'h00);
    axw(REG_STATUS, 32'h30, r);
    iss(OP_WD_PRE1, 8'h10, 8'h00);
    iss(OP_NOP, 8'h10, 8'h00);
    rdc(REG_STATUS, 32'h30);
    rdc(REG_WDOG, 32'h01);
    chk(mdl.clr_cnt, c + 1);
    iss(OP_WD_PRE2, 8'h10, 8'h00);
    rdc(REG_STATUS, 32'h00);
    rdc(REG_WDOG, 32'h00);
    iss(OP_WD_PRE2, 8'h10, 8'h00);
    iss(OP_WD_PRE2, 8'h10, 8'h00);
    rdc(REG_WDOG, 32'h02);
    iss(OP_WD_PRE1, 8'h10, 8'h00);
    rdc(REG_WDOG, 32'h00);
    chk(mdl.clr_cnt, c + 3);
  endtask : sc_wdog
  // expiry sets the flag, then halt and wake
  task automatic sc_halt;
    logic [1:0] r;
    int c;
    axw(REG_STATUS, 32'h00, r);
    wdt_expired <= 1'b1;
    @(posedge aclk);
    wdt_expired <= 1'b0;
    rdc(REG_STATUS, 32'h20);
    c = mdl.clr_cnt;
    iss(OP_HALT, 8'h10, 8'h00);
    repeat (3) @(posedge aclk);
    chk({30'h0, clk_stop, issue_ready}, 32'h2);
    wake <= 1'b1;
    @(posedge aclk);
    wake <= 1'b0;
    @(negedge aclk);
    chk({30'h0, clk_stop, issue_ready}, 32'h1);
    rdc(REG_STATUS, 32'h10);
    chk(mdl.clr_cnt, c + 1);
  endtask : sc_halt
  // write to the pc low byte stalls issue
  task automatic sc_pcl;
    logic [1:0] r;
    int c;
    c = 0;
    mdl.mem[PCL_ADDR] = 8'h10;
    axw(REG_WORK, 32'h01, r);
    iss(OP_ADD_M, PCL_ADDR, 8'h00);
    repeat (8)
    begin
      @(negedge aclk);
      if (!issue_ready) c++;
    end
    chk(c, 4);
    chk({24'h0, mdl.mem[PCL_ADDR]}, 32'h11);
  endtask : sc_pcl
  // reset values, read-only and unmapped places
  task automatic sc_bus;
    logic [31:0] d;
    logic [1:0] r;
    rdc(REG_WORK, 32'h00);
    rdc(REG_STATUS, 32'h00);
    rdc(REG_WDOG, 32'h00);
    // a write with lane 0 disabled leaves the register alone
    s_axi_wstrb <= 4'h0;
    axw(REG_WORK, 32'h55, r);
    s_axi_wstrb <= 4'hf;
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rdc(REG_WORK, 32'h00);
    axw(REG_WDOG, 32'h03, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rdc(REG_WDOG, 32'h00);
    axw(8'h0c, 32'h01, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axr(8'h0c, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(d, 32'h0);
  endtask : sc_bus
  // main sequence
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    sc_bus;
    sc_alu;
    sc_call;
    sc_wdog;
    sc_halt;
    sc_pcl;
    // reset in mid-run returns work and flags to their reset values
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(REG_WORK, 32'h00);
    rdc(REG_STATUS, 32'h00);
    end_sim;
  end
endmodule : test_ieu_exec
